// File: logic/branch_control_decode.v
`timescale 1ns/10ps
`include "branch_control_map.vh"

// Summary of operation
// - Short branches test carry set, carry clear, zero set or zero clear in 1 byte, 2 cycles.
// - The short branch displacement is 5-bit signed, reaching -15 to +16 from its address.
// - Bit-test branches are 3 bytes, 5 cycles, on bit clear or set, span -126 to +129.
// - Every bit-test branch copies the tested bit into carry and leaves zero alone.
// - Bit set and clear change one data byte bit in 2 bytes and 4 cycles, flags kept.
// - No-op, return, interrupt return, stop and wait take 1 byte and 2 cycles.
// - With the watchdog selected, stop is replaced by a wait.
// - Jump and call take a 12-bit target in 2 bytes and 4 cycles; call saves the return.
// - A clear opcode bit 0 selects a short branch; otherwise the low nibble selects the instruction and the high nibble carries operands, bar whole-byte opcodes.
// - Short branch opcodes hold condition, direction and span; untaken falls through.
module branch_control_decode (
  input wire i_sys_clk,
  input wire i_srst,
  output wire [11:0] o_pm_addr,
  input wire [7:0] i_pm_data,
  output wire [7:0] o_dm_addr,
  output wire [7:0] o_dm_wdata,
  output wire o_dm_we,
  input wire [7:0] i_dm_rdata,
  output wire o_stack_push,
  output wire [11:0] o_stack_data,
  output wire o_stack_pop,
  input wire [11:0] i_stack_data,
  input wire i_saved_z,
  input wire i_saved_c,
  input wire i_alu_flag_we,
  input wire i_alu_z,
  input wire i_alu_c,
  output wire o_flag_z,
  output wire o_flag_c,
  input wire i_wdg_sel,
  input wire i_wake,
  output wire o_stop_req,
  output wire o_wait_req,
  output wire o_other_op,
  output wire [7:0] o_other_code,
  output wire o_instr_done
);
  localparam [1:0] ST_RUN = 2'b01;
  localparam [1:0] ST_HALT = 2'b10;

  reg [1:0] state_r;
  reg [2:0] k_r;
  reg [11:0] pc_r;
  reg [11:0] fa_r;
  reg [7:0] op_r;
  reg [7:0] b1_r;
  reg [7:0] ee_r;
  reg bit_r;
  reg z_r;
  reg c_r;
  reg [7:0] dm_addr_r;
  reg [7:0] dm_wdata_r;
  reg dm_we_r;
  reg push_r;
  reg [11:0] sdata_r;
  reg stop_r;
  reg wait_r;
  reg other_r;
  reg [7:0] other_code_r;
  reg done_r;
  reg [11:0] npc;

  wire [7:0] op_cur = (k_r == `BCD_K_OP) ? i_pm_data : op_r;
  wire is_rel, is_btest, is_bitop, is_jump, is_call;
  wire is_ret, is_return_from_interrupt, is_stop, is_wait, is_other;
  wire [2:0] last_k;
  wire [2:0] bit_idx;

  branch_ctl_opdec u_dec (
    .i_op(op_cur),
    .o_is_rel(is_rel),
    .o_is_btest(is_btest),
    .o_is_bitop(is_bitop),
    .o_is_jump(is_jump),
    .o_is_call(is_call),
    .o_is_ret(is_ret),
    .o_is_return_from_interrupt(is_return_from_interrupt),
    .o_is_stop(is_stop),
    .o_is_wait(is_wait),
    .o_is_other(is_other),
    .o_last_k(last_k),
    .o_bit_idx(bit_idx)
  );

  wire run = (state_r == ST_RUN);
  wire fin = run && (k_r != 3'h0) && (k_r == last_k);
  wire set_form = op_cur[4];
  wire dm_bit = i_dm_rdata[bit_idx];

  // Condition of a short branch
  reg cond_ok;
  always @* begin
    case (op_cur[2:1])
      `BCD_COND_Z_CLR: cond_ok = ~z_r;
      `BCD_COND_C_CLR: cond_ok = ~c_r;
      `BCD_COND_Z_SET: cond_ok = z_r;
      `BCD_COND_C_SET: cond_ok = c_r;
      default: cond_ok = 1'b0;
    endcase
  end

  // Direction bit and span form one signed 5-bit step
  wire [11:0] rel_disp = {{8{op_cur[7]}}, op_cur[6:3]};
  wire [11:0] bt_disp = {{4{ee_r[7]}}, ee_r};

  // Next program counter on completion
  always @* begin
    npc = pc_r + 12'h001;
    if (is_rel) begin
      if (cond_ok) begin
        npc = pc_r + 12'h001 + rel_disp;
      end else begin
        npc = pc_r + 12'h001;
      end
    end else if (is_btest) begin
      if (bit_r == set_form) begin
        npc = pc_r + 12'h002 + bt_disp;
      end else begin
        npc = pc_r + 12'h003;
      end
    end else if (is_bitop) begin
      npc = pc_r + 12'h002;
    end else if (is_jump || is_call) begin
      npc = {op_cur[7:4], b1_r};
    end else if (is_ret || is_return_from_interrupt) begin
      npc = i_stack_data;
    end
  end

  always @(posedge i_sys_clk) begin
    if (i_srst) begin
      state_r <= ST_RUN;
      k_r <= 3'h0;
      pc_r <= 12'h000;
      fa_r <= 12'h000;
      op_r <= 8'h00;
      b1_r <= 8'h00;
      ee_r <= 8'h00;
      bit_r <= 1'b0;
      z_r <= 1'b0;
      c_r <= 1'b0;
      dm_addr_r <= 8'h00;
      dm_wdata_r <= 8'h00;
      dm_we_r <= 1'b0;
      push_r <= 1'b0;
      sdata_r <= 12'h000;
      stop_r <= 1'b0;
      wait_r <= 1'b0;
      other_r <= 1'b0;
      other_code_r <= 8'h00;
      done_r <= 1'b0;
    end else begin
      dm_we_r <= 1'b0;
      push_r <= 1'b0;
      other_r <= 1'b0;
      done_r <= fin;
      if (i_alu_flag_we) begin
        z_r <= i_alu_z;
        c_r <= i_alu_c;
      end
      case (state_r)
        ST_RUN: begin
          if (k_r == `BCD_K_OP) begin
            op_r <= i_pm_data;
          end
          if (k_r == `BCD_K_B1) begin
            b1_r <= i_pm_data;
            dm_addr_r <= i_pm_data;
          end
          if (k_r == `BCD_K_B2) begin
            ee_r <= i_pm_data;
            if (is_btest) begin
              bit_r <= dm_bit;
              c_r <= dm_bit;
            end
            if (is_bitop) begin
              dm_we_r <= 1'b1;
              dm_wdata_r <= set_form ? (i_dm_rdata | (8'h01 << bit_idx))
                                     : (i_dm_rdata & ~(8'h01 << bit_idx));
            end
          end
          if (fin) begin
            k_r <= 3'h0;
            pc_r <= npc;
            fa_r <= npc;
            if (is_return_from_interrupt) begin
              z_r <= i_saved_z;
              c_r <= i_saved_c;
            end
            if (is_call) begin
              push_r <= 1'b1;
              sdata_r <= pc_r + 12'h002;
            end
            if (is_other) begin
              other_r <= 1'b1;
              other_code_r <= op_cur;
            end
            if (is_stop && !i_wdg_sel) begin
              stop_r <= 1'b1;
              state_r <= ST_HALT;
            end
            if (is_wait || (is_stop && i_wdg_sel)) begin
              wait_r <= 1'b1;
              state_r <= ST_HALT;
            end
          end else begin
            k_r <= k_r + 3'h1;
            if (k_r < `BCD_K_B1) begin
              fa_r <= fa_r + 12'h001;
            end
          end
        end
        ST_HALT: begin
          if (i_wake) begin
            stop_r <= 1'b0;
            wait_r <= 1'b0;
            state_r <= ST_RUN;
          end
        end
        default: begin
          state_r <= ST_RUN;
          k_r <= 3'h0;
        end
      endcase
    end
  end

  assign o_pm_addr = fa_r;
  assign o_dm_addr = dm_addr_r;
  assign o_dm_wdata = dm_wdata_r;
  assign o_dm_we = dm_we_r;
  assign o_stack_push = push_r;
  assign o_stack_data = sdata_r;
  assign o_stack_pop = fin && (is_ret || is_return_from_interrupt);
  assign o_flag_z = z_r;
  assign o_flag_c = c_r;
  assign o_stop_req = stop_r;
  assign o_wait_req = wait_r;
  assign o_other_op = other_r;
  assign o_other_code = other_code_r;
  assign o_instr_done = done_r;
endmodule

// File: logic/branch_control_map.vh
`ifndef BRANCH_CONTROL_MAP_VH
`define BRANCH_CONTROL_MAP_VH

// Opcode low-nibble codes
`define BCD_LO_CALL 4'h1
`define BCD_LO_BTEST 4'h3
`define BCD_LO_JUMP 4'h9
`define BCD_LO_BITOP 4'hb
// Relative branch condition field, opcode bits 2:1
`define BCD_COND_Z_CLR 2'h0
`define BCD_COND_C_CLR 2'h1
`define BCD_COND_Z_SET 2'h2
`define BCD_COND_C_SET 2'h3
// Whole-byte control opcodes (values arbitrary)
`define BCD_OP_NOP 8'h04
`define BCD_OP_RET 8'hcd
`define BCD_OP_RETURN_FROM_INTERRUPT 8'h4d
`define BCD_OP_STOP 8'h6d
`define BCD_OP_WAIT 8'hed
// Cycles per instruction
`define BCD_CYC_REL 3'h2
`define BCD_CYC_CTRL 3'h2
`define BCD_CYC_BTEST 3'h5
`define BCD_CYC_BITOP 3'h4
`define BCD_CYC_JUMP 3'h4
`define BCD_CYC_OTHER 3'h2
// Instruction-phase indices
`define BCD_K_OP 3'h1
`define BCD_K_B1 3'h2
`define BCD_K_B2 3'h3

`endif

// File: logic/branch_ctl_opdec.v
`timescale 1ns/10ps
`include "branch_control_map.vh"

// Pure opcode classifier
module branch_ctl_opdec (
  input wire [7:0] i_op,
  output reg o_is_rel,
  output reg o_is_btest,
  output reg o_is_bitop,
  output reg o_is_jump,
  output reg o_is_call,
  output reg o_is_ret,
  output reg o_is_return_from_interrupt,
  output reg o_is_stop,
  output reg o_is_wait,
  output reg o_is_other,
  output reg [2:0] o_last_k,
  output wire [2:0] o_bit_idx
);
  // Bit index sits bit-reversed in opcode bits 7:5
  assign o_bit_idx = {i_op[5], i_op[6], i_op[7]};

  always @* begin
    o_is_rel = 1'b0;
    o_is_btest = 1'b0;
    o_is_bitop = 1'b0;
    o_is_jump = 1'b0;
    o_is_call = 1'b0;
    o_is_ret = 1'b0;
    o_is_return_from_interrupt = 1'b0;
    o_is_stop = 1'b0;
    o_is_wait = 1'b0;
    o_is_other = 1'b0;
    o_last_k = `BCD_CYC_OTHER - 3'h1;
    if (i_op == `BCD_OP_RET) begin
      o_is_ret = 1'b1;
      o_last_k = `BCD_CYC_CTRL - 3'h1;
    end else if (i_op == `BCD_OP_RETURN_FROM_INTERRUPT) begin
      o_is_return_from_interrupt = 1'b1;
      o_last_k = `BCD_CYC_CTRL - 3'h1;
    end else if (i_op == `BCD_OP_STOP) begin
      o_is_stop = 1'b1;
      o_last_k = `BCD_CYC_CTRL - 3'h1;
    end else if (i_op == `BCD_OP_WAIT) begin
      o_is_wait = 1'b1;
      o_last_k = `BCD_CYC_CTRL - 3'h1;
    end else if (i_op[0] == 1'b0) begin
      // Zero-span zero-set branch doubles as the no-op
      o_is_rel = 1'b1;
      o_last_k = `BCD_CYC_REL - 3'h1;
    end else if (i_op[3:0] == `BCD_LO_BTEST) begin
      o_is_btest = 1'b1;
      o_last_k = `BCD_CYC_BTEST - 3'h1;
    end else if (i_op[3:0] == `BCD_LO_CALL) begin
      o_is_call = 1'b1;
      o_last_k = `BCD_CYC_JUMP - 3'h1;
    end else if (i_op[3:0] == `BCD_LO_JUMP) begin
      o_is_jump = 1'b1;
      o_last_k = `BCD_CYC_JUMP - 3'h1;
    end else if (i_op[3:0] == `BCD_LO_BITOP) begin
      o_is_bitop = 1'b1;
      o_last_k = `BCD_CYC_BITOP - 3'h1;
    end else begin
      o_is_other = 1'b1;
    end
  end
endmodule

// File: sim/branch_control_decode_monitor.sv
`timescale 1ns/10ps
module branch_control_decode_monitor (
  input wire i_sys_clk,
  input wire i_srst,
  input wire [11:0] o_pm_addr,
  input wire o_dm_we,
  input wire o_stack_push,
  input wire o_stack_pop,
  input wire i_wdg_sel,
  input wire i_wake,
  input wire o_stop_req,
  input wire o_wait_req,
  input wire o_instr_done
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_srst);
  // One-cycle completion pulse
  sequence s_done_pulse;
    o_instr_done ##1 !o_instr_done;
  endsequence
  a_pop_then_done: assert property (o_stack_pop |=> s_done_pulse)
    else $error("pop not followed by done");
  a_push_with_done: assert property (o_stack_push |-> s_done_pulse)
    else $error("push not with done");
  a_write_with_done: assert property (o_dm_we |-> s_done_pulse)
    else $error("bit write not with done");
  a_done_gap: assert property (o_instr_done |=> !o_instr_done)
    else $error("done pulses too close");
  a_halt_excl: assert property (o_stop_req |-> !o_wait_req)
    else $error("stop and wait together");
  a_stop_wdg_off: assert property ($rose(o_stop_req) |-> !$past(i_wdg_sel))
    else $error("stop entered with watchdog");
  a_halt_on_done: assert property ($rose(o_stop_req) |-> s_done_pulse)
    else $error("stop entry without done");
  a_halt_no_fetch: assert property (o_stop_req && $past(o_stop_req) && !$past(i_wake)
    && !$past(i_wake, 2) |-> $stable(o_pm_addr))
    else $error("fetch moved while halted");
endmodule

// File: sim/branch_control_decode_tb_top.sv
`timescale 1ns/10ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
  $display("wrong value %s expected %0h seen %0h", nm, e, a); end end
module branch_control_decode_tb_top;
  reg i_sys_clk = 1'b0;
  reg i_srst = 1'b1;
  reg [7:0] i_pm_data = 8'h00;
  reg [7:0] dm_byte = 8'h00;
  reg i_alu_flag_we = 1'b0;
  reg i_wdg_sel = 1'b0;
  reg i_wake = 1'b0;
  reg [7:0] pm [0:4095];
  wire [11:0] o_pm_addr, o_stack_data;
  wire [7:0] o_dm_addr, o_dm_wdata, o_other_code;
  wire o_dm_we, o_stack_push, o_stack_pop, o_flag_z, o_flag_c;
  wire o_stop_req, o_wait_req, o_other_op, o_instr_done;
  integer error_cnt = 0;
  integer n_compared = 0;
  integer n;
  always #5 i_sys_clk = ~i_sys_clk;
  always @(posedge i_sys_clk) i_pm_data <= pm[o_pm_addr];
  branch_control_decode u_branch_control_decode (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
    .o_pm_addr(o_pm_addr), .i_pm_data(i_pm_data), .o_dm_addr(o_dm_addr),
    .o_dm_wdata(o_dm_wdata), .o_dm_we(o_dm_we), .i_dm_rdata(dm_byte),
    .o_stack_push(o_stack_push), .o_stack_data(o_stack_data), .o_stack_pop(o_stack_pop),
    .i_stack_data(12'h155), .i_saved_z(1'b1), .i_saved_c(1'b1),
    .i_alu_flag_we(i_alu_flag_we), .i_alu_z(1'b0), .i_alu_c(1'b0), .o_flag_z(o_flag_z),
    .o_flag_c(o_flag_c), .i_wdg_sel(i_wdg_sel), .i_wake(i_wake), .o_stop_req(o_stop_req),
    .o_wait_req(o_wait_req), .o_other_op(o_other_op), .o_other_code(o_other_code),
    .o_instr_done(o_instr_done));
  task end_sim;
    begin
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task wait_done;
    begin
      @(negedge i_sys_clk);
      while (o_instr_done !== 1'b1 && n < 60) begin
        n = n + 1;
        @(negedge i_sys_clk);
      end
    end
  endtask
  task start;
    begin
      @(posedge i_sys_clk);
      i_srst <= 1'b1;
      repeat (2) @(posedge i_sys_clk);
      i_srst <= 1'b0;
      n = 0;
      wait_done;
    end
  endtask
  task step(input integer cyc, input [11:0] adr);
    begin
      n = 1;
      wait_done;
      `CHK("cycles", cyc, n)
      `CHK("next_pc", adr, o_pm_addr)
    end
  endtask
  task t_rel;
    begin
      pm[1] = 8'h30; pm[8] = 8'h34; pm[9] = 8'h32; pm[16] = 8'h36;
      pm[12'h011] = 8'h78; pm[12'h021] = 8'h80; pm[12'h012] = 8'h05;
      start;
      step(2, 12'h008);
      step(2, 12'h009);
      step(2, 12'h010);
      step(2, 12'h011);
      `CHK("flags", 2'b00, {o_flag_z, o_flag_c})
      step(2, 12'h021);
      step(2, 12'h012);
      step(2, 12'h013);
      `CHK("other", 9'h105, {o_other_op, o_other_code})
    end
  endtask
  task t_btest;
    begin
      pm[1] = 8'h13; pm[2] = 8'h40; pm[3] = 8'h05; pm[8] = 8'h83; pm[9] = 8'h41; pm[10] = 8'h80;
      @(posedge i_sys_clk);
      dm_byte <= 8'h01;
      start;
      step(5, 12'h008);
      `CHK("flags", 2'b01, {o_flag_z, o_flag_c})
      `CHK("dm_addr", 8'h40, o_dm_addr)
      step(5, 12'hf8a);
      `CHK("carry", 1'b0, o_flag_c)
    end
  endtask
  task t_bitop;
    begin
      pm[1] = 8'hfb; pm[2] = 8'h40; pm[3] = 8'h0b; pm[4] = 8'h41;
      start;
      step(4, 12'h003);
      `CHK("write", 9'h181, {o_dm_we, o_dm_wdata})
      step(4, 12'h005);
      `CHK("write", 9'h100, {o_dm_we, o_dm_wdata})
      `CHK("flags", 2'b00, {o_flag_z, o_flag_c})
    end
  endtask
  task t_jump;
    begin
      pm[1] = 8'h29; pm[2] = 8'h10; pm[12'h210] = 8'h31; pm[12'h211] = 8'h20;
      pm[12'h320] = 8'hcd; pm[12'h155] = 8'h4d;
      start;
      step(4, 12'h210);
      step(4, 12'h320);
      `CHK("push", 13'h1212, {o_stack_push, o_stack_data})
      step(2, 12'h155);
      `CHK("flags", 2'b00, {o_flag_z, o_flag_c})
      step(2, 12'h155);
      `CHK("flags", 2'b11, {o_flag_z, o_flag_c})
    end
  endtask
  task t_halt;
    begin
      pm[1] = 8'h6d; pm[2] = 8'hed;
      start;
      step(2, 12'h002);
      repeat (4) @(negedge i_sys_clk);
      `CHK("halt", 14'h2002, {o_stop_req, o_wait_req, o_pm_addr})
      @(posedge i_sys_clk);
      i_wake <= 1'b1;
      @(posedge i_sys_clk);
      i_wake <= 1'b0;
      repeat (3) @(negedge i_sys_clk);
      `CHK("wait", 2'b01, {o_stop_req, o_wait_req})
      @(posedge i_sys_clk);
      i_wdg_sel <= 1'b1;
      start;
      step(2, 12'h002);
      `CHK("halt", 2'b01, {o_stop_req, o_wait_req})
    end
  endtask
  initial begin
    for (n = 0; n < 4096; n = n + 1) pm[n] = 8'h04;
    repeat (12) @(posedge i_sys_clk);
    t_rel;
    t_btest;
    t_bitop;
    t_jump;
    t_halt;
    end_sim;
  end
  initial begin
    #20000;
    error_cnt++;
    end_sim;
  end
endmodule
bind branch_control_decode branch_control_decode_monitor u_mon (.i_sys_clk(i_sys_clk),
  .i_srst(i_srst), .o_pm_addr(o_pm_addr), .o_dm_we(o_dm_we), .o_stack_push(o_stack_push),
  .o_stack_pop(o_stack_pop), .i_wdg_sel(i_wdg_sel), .i_wake(i_wake), .o_stop_req(o_stop_req),
  .o_wait_req(o_wait_req), .o_instr_done(o_instr_done));
